// ### design/sci_map.svh
/*
 Register indices, reset values and timing constants for the servo command
 and terminal conditioning block. Assumes one 16-bit register per index.
*/
`ifndef SCI_MAP_SVH
`define SCI_MAP_SVH
`define SCI_IDX_SPD_GAIN      5'h00
`define SCI_IDX_SPD_REV       5'h01
`define SCI_IDX_SPD_OFS       5'h02
`define SCI_IDX_SPD_DZ        5'h03
`define SCI_IDX_SPD_FLT       5'h04
`define SCI_IDX_TRQ_GAIN      5'h05
`define SCI_IDX_TRQ_REV       5'h06
`define SCI_IDX_TRQ_OFS       5'h07
`define SCI_IDX_TRQ_CAP       5'h08
`define SCI_IDX_TRQ_FLT       5'h09
`define SCI_IDX_FRC_LO        5'h0A
`define SCI_IDX_FRC_HI        5'h0B
`define SCI_IDX_INV_LO        5'h0C
`define SCI_IDX_INV_HI        5'h0D
`define SCI_IDX_INV_OUT       5'h0E
`define SCI_IDX_DEB_TIME      5'h0F
`define SCI_IDX_STATUS        5'h10
`define SCI_IDX_TRQ_MODE      5'h11
`define SCI_RST_SPD_GAIN      16'h012C
`define SCI_RST_SPD_FLT       16'h012C
`define SCI_RST_TRQ_GAIN      16'h0064
`define SCI_RST_TRQ_CAP       16'h09C4
`define SCI_RST_TRQ_FLT       16'h012C
`define SCI_RST_DEB_TIME      16'h0010
`define SCI_FLT_FULL          16'h03E8
`define SCI_DEB_TICK_US       1
`define SCI_CLK_MHZ           20
`define SCI_DEB_TICK_CYC      (`SCI_DEB_TICK_US * `SCI_CLK_MHZ)
`endif

// ### design/sci_pkg.sv
/*
 Types for the servo command conditioning block.
 Assumes the map header is included by users for numbers.
*/
package sci_pkg;
	typedef struct packed {
		logic [3:0] lo;
		logic [3:0] hi;
	} sci_term_s;
	typedef struct packed {
		logic signed [15:0] spd;
		logic signed [15:0] trq;
	} sci_ana_s;
endpackage

// ### design/sci_core.sv
/*
 Servo analog command conditioning and terminal logic with register port.
 Assumes synchronous inputs, signed 16-bit samples, one valid sample per clock.
*/
// Implementation choices: the plain strobed port and the address map.
// Operation
// (RL1) Speed command equals filtered input times speed gain.
// (RL2) Speed reverse bit negates the speed command.
// (RL3) Speed zero offset is added to the speed input.
// (RL4) Speed inside the dead zone band gives zero command.
// (RL5) Speed input is low-pass filtered, larger setting is faster.
// (RL6) Torque command equals filtered input times torque gain.
// (RL7) Torque reverse bit negates the torque command.
// (RL8) Torque zero offset is added to the torque input.
// (RL9) In torque mode speed is clamped to the speed cap; the core only drives the cap on SPD_LIMIT and leaves SPD_CMD unclamped.
// (RL10) Torque input is low-pass filtered, larger setting is faster.
// (RL11) Low force word asserts low terminals per bit.
// (RL12) High force word asserts high terminals per bit.
// (RL13) Low inversion word inverts low terminals per bit.
// (RL14) High inversion word inverts high terminals per bit.
// (RL15) Output inversion word inverts output terminals per bit.
// (RL16) Every input terminal is debounced by the programmed time.
// (RL17) Debounce and inversion come first, then force is ORed.
`include "sci_map.svh"
`timescale 1ns/1ps
`default_nettype none
module sci_core #(
	parameter int DEB_TICK = `SCI_DEB_TICK_CYC
) (
	input  wire logic               CLK_SYS,
	input  wire logic               SYS_RST,
	input  wire logic [4:0]         REG_ADDR,
	input  wire logic [15:0]        REG_WDATA,
	input  wire logic               REG_WR,
	input  wire logic               REG_RD,
	output logic      [15:0]        REG_RDATA,
	input  wire sci_pkg::sci_ana_s  ANA_IN,
	input  wire sci_pkg::sci_term_s TERM_IN,
	input  wire logic [3:0]         STAT_IN,
	output sci_pkg::sci_term_s      TERM_OUT,
	output logic [3:0]              STAT_OUT,
	output logic signed [31:0]      SPD_CMD,
	output logic signed [31:0]      TRQ_CMD,
	output logic signed [15:0]      SPD_LIMIT
);
	// Configuration registers
	logic [15:0] spd_gain_r, spd_ofs_r, spd_dz_r, spd_flt_r;
	logic [15:0] trq_gain_r, trq_ofs_r, trq_cap_r, trq_flt_r;
	logic [15:0] deb_time_r;
	logic        spd_rev_r, trq_rev_r, trq_mode_r;
	logic [3:0]  frc_lo_r, frc_hi_r, inv_lo_r, inv_hi_r, inv_out_r;
	logic [15:0] rdata_r, rdata_nxt;

	// First-order filter step: y += (x - y) * k / full
	function automatic logic signed [15:0] lpf_step(input logic signed [15:0] y,
		input logic signed [15:0] x, input logic [15:0] k);
		logic signed [33:0] d;
		d = 34'(($signed({x[15], x}) - $signed({y[15], y})) * $signed({1'b0, k}));
		lpf_step = 16'(y + 16'(d / $signed(34'(`SCI_FLT_FULL))));
	endfunction

	// Saturating offset add to 16 bits
	function automatic logic signed [15:0] sat_add(input logic signed [15:0] a,
		input logic signed [15:0] b);
		logic signed [16:0] s;
		s = $signed({a[15], a}) + $signed({b[15], b});
		if (s > 17'sd32767)
			sat_add = 16'sh7FFF;
		else if (s < -17'sd32768)
			sat_add = 16'sh8000;
		else
			sat_add = s[15:0];
	endfunction

	// Register write port
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			spd_gain_r <= `SCI_RST_SPD_GAIN;
			spd_rev_r  <= 1'b0;
			spd_ofs_r  <= 16'h0000;
			spd_dz_r   <= 16'h0000;
			spd_flt_r  <= `SCI_RST_SPD_FLT;
			trq_gain_r <= `SCI_RST_TRQ_GAIN;
			trq_rev_r  <= 1'b0;
			trq_ofs_r  <= 16'h0000;
			trq_cap_r  <= `SCI_RST_TRQ_CAP;
			trq_flt_r  <= `SCI_RST_TRQ_FLT;
			frc_lo_r   <= 4'h0;
			frc_hi_r   <= 4'h0;
			inv_lo_r   <= 4'h0;
			inv_hi_r   <= 4'h0;
			inv_out_r  <= 4'h0;
			deb_time_r <= `SCI_RST_DEB_TIME;
			trq_mode_r <= 1'b0;
		end else if (REG_WR) begin
			unique case (REG_ADDR)
				`SCI_IDX_SPD_GAIN: spd_gain_r <= REG_WDATA;
				`SCI_IDX_SPD_REV:  spd_rev_r  <= REG_WDATA[0];
				`SCI_IDX_SPD_OFS:  spd_ofs_r  <= REG_WDATA;
				`SCI_IDX_SPD_DZ:   spd_dz_r   <= REG_WDATA;
				`SCI_IDX_SPD_FLT:  spd_flt_r  <= REG_WDATA;
				`SCI_IDX_TRQ_GAIN: trq_gain_r <= REG_WDATA;
				`SCI_IDX_TRQ_REV:  trq_rev_r  <= REG_WDATA[0];
				`SCI_IDX_TRQ_OFS:  trq_ofs_r  <= REG_WDATA;
				`SCI_IDX_TRQ_CAP:  trq_cap_r  <= REG_WDATA;
				`SCI_IDX_TRQ_FLT:  trq_flt_r  <= REG_WDATA;
				`SCI_IDX_FRC_LO:   frc_lo_r   <= REG_WDATA[3:0];
				`SCI_IDX_FRC_HI:   frc_hi_r   <= REG_WDATA[3:0];
				`SCI_IDX_INV_LO:   inv_lo_r   <= REG_WDATA[3:0];
				`SCI_IDX_INV_HI:   inv_hi_r   <= REG_WDATA[3:0];
				`SCI_IDX_INV_OUT:  inv_out_r  <= REG_WDATA[3:0];
				`SCI_IDX_DEB_TIME: deb_time_r <= REG_WDATA;
				`SCI_IDX_TRQ_MODE: trq_mode_r <= REG_WDATA[0];
				default: ;
			endcase
		end
	end

	// Debounce tick prescaler, one tick per microsecond
	logic [15:0] tick_cnt_r;
	wire         deb_tick = (tick_cnt_r == 16'(DEB_TICK - 1));
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST)
			tick_cnt_r <= 16'h0000;
		else
			tick_cnt_r <= deb_tick ? 16'h0000 : tick_cnt_r + 16'h0001;
	end

	// Per-terminal debounce: level must hold deb_time ticks
	wire  [7:0]  raw_in = {TERM_IN.hi, TERM_IN.lo};
	logic [7:0]  deb_r;
	logic [15:0] deb_cnt_r [8];
	for (genvar i = 0; i < 8; i++) begin : g_deb
		always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
			if (SYS_RST) begin
				deb_cnt_r[i] <= 16'h0000;
				deb_r[i]     <= 1'b0;
			end else if (raw_in[i] == deb_r[i]) begin
				deb_cnt_r[i] <= 16'h0000;
			end else if (deb_tick) begin
				if (deb_cnt_r[i] + 16'h0001 >= deb_time_r) begin // RL16
					deb_r[i]     <= raw_in[i];
					deb_cnt_r[i] <= 16'h0000;
				end else begin
					deb_cnt_r[i] <= deb_cnt_r[i] + 16'h0001;
				end
			end
		end
	end

	// Inversion then force, per terminal group
	wire [3:0] term_lo = (deb_r[3:0] ^ inv_lo_r) | frc_lo_r; // RL13 RL11 RL17
	wire [3:0] term_hi = (deb_r[7:4] ^ inv_hi_r) | frc_hi_r; // RL14 RL12 RL17
	assign TERM_OUT.lo = term_lo;
	assign TERM_OUT.hi = term_hi;

	// Output terminal inversion
	logic [3:0] stat_r;
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST)
			stat_r <= 4'h0;
		else
			stat_r <= STAT_IN ^ inv_out_r; // RL15
	end
	assign STAT_OUT = stat_r;

	// Offset correction ahead of the filters
	wire signed [15:0] spd_corr = sat_add(ANA_IN.spd, spd_ofs_r); // RL3
	wire signed [15:0] trq_corr = sat_add(ANA_IN.trq, trq_ofs_r); // RL8

	// Low-pass filter state
	logic signed [15:0] spd_f_r, trq_f_r;
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			spd_f_r <= 16'sh0000;
			trq_f_r <= 16'sh0000;
		end else begin
			spd_f_r <= lpf_step(spd_f_r, spd_corr, spd_flt_r); // RL5
			trq_f_r <= lpf_step(trq_f_r, trq_corr, trq_flt_r); // RL10
		end
	end

	// Dead zone band is symmetric on the magnitude of the setting
	wire signed [15:0] dz_abs  = spd_dz_r[15] ? 16'(-$signed(spd_dz_r)) : spd_dz_r;
	wire               in_dz   = ($signed(spd_f_r) <= dz_abs) &&
	                             ($signed(spd_f_r) >= -dz_abs); // RL4
	wire signed [31:0] spd_mul = 32'($signed(spd_f_r) * $signed({1'b0, spd_gain_r})); // RL1
	wire signed [31:0] trq_mul = 32'($signed(trq_f_r) * $signed({1'b0, trq_gain_r})); // RL6
	wire signed [31:0] spd_dir = spd_rev_r ? -spd_mul : spd_mul; // RL2
	wire signed [31:0] trq_dir = trq_rev_r ? -trq_mul : trq_mul; // RL7

	// Command outputs from flip-flops
	logic signed [31:0] spd_cmd_r, trq_cmd_r;
	logic signed [15:0] spd_lim_r;
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST) begin
			spd_cmd_r <= 32'sh0;
			trq_cmd_r <= 32'sh0;
			spd_lim_r <= 16'sh0;
		end else begin
			spd_cmd_r <= in_dz ? 32'sh0 : spd_dir; // RL4
			trq_cmd_r <= trq_dir;
			spd_lim_r <= trq_mode_r ? trq_cap_r : 16'sh7FFF; // RL9
		end
	end
	assign SPD_CMD   = spd_cmd_r;
	assign TRQ_CMD   = trq_cmd_r;
	assign SPD_LIMIT = spd_lim_r;

	// Read mux, data stands in the cycle after the strobe
	always_comb begin
		unique case (REG_ADDR)
			`SCI_IDX_SPD_GAIN: rdata_nxt = spd_gain_r;
			`SCI_IDX_SPD_REV:  rdata_nxt = {15'h0000, spd_rev_r};
			`SCI_IDX_SPD_OFS:  rdata_nxt = spd_ofs_r;
			`SCI_IDX_SPD_DZ:   rdata_nxt = spd_dz_r;
			`SCI_IDX_SPD_FLT:  rdata_nxt = spd_flt_r;
			`SCI_IDX_TRQ_GAIN: rdata_nxt = trq_gain_r;
			`SCI_IDX_TRQ_REV:  rdata_nxt = {15'h0000, trq_rev_r};
			`SCI_IDX_TRQ_OFS:  rdata_nxt = trq_ofs_r;
			`SCI_IDX_TRQ_CAP:  rdata_nxt = trq_cap_r;
			`SCI_IDX_TRQ_FLT:  rdata_nxt = trq_flt_r;
			`SCI_IDX_FRC_LO:   rdata_nxt = {12'h000, frc_lo_r};
			`SCI_IDX_FRC_HI:   rdata_nxt = {12'h000, frc_hi_r};
			`SCI_IDX_INV_LO:   rdata_nxt = {12'h000, inv_lo_r};
			`SCI_IDX_INV_HI:   rdata_nxt = {12'h000, inv_hi_r};
			`SCI_IDX_INV_OUT:  rdata_nxt = {12'h000, inv_out_r};
			`SCI_IDX_DEB_TIME: rdata_nxt = deb_time_r;
			`SCI_IDX_STATUS:   rdata_nxt = {8'h00, term_hi, term_lo};
			`SCI_IDX_TRQ_MODE: rdata_nxt = {15'h0000, trq_mode_r};
			default:           rdata_nxt = 16'h0000;
		endcase
	end
	always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
		if (SYS_RST)
			rdata_r <= 16'h0000;
		else
			rdata_r <= REG_RD ? rdata_nxt : 16'h0000;
	end
	assign REG_RDATA = rdata_r;

	// Assertions
	a_force_low_wins: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		((frc_lo_r & ~TERM_OUT.lo) == 4'h0)) else $error("forced low input not active"); // RL11
	a_force_high_wins: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		((frc_hi_r & ~TERM_OUT.hi) == 4'h0)) else $error("forced high input not active"); // RL12
	a_inv_low_path: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(frc_lo_r == 4'h0) |-> (TERM_OUT.lo == (deb_r[3:0] ^ inv_lo_r)))
		else $error("low inversion wrong"); // RL13
	a_inv_high_path: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(frc_hi_r == 4'h0) |-> (TERM_OUT.hi == (deb_r[7:4] ^ inv_hi_r)))
		else $error("high inversion wrong"); // RL14 RL17
	a_out_invert: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		1'b1 |=> (STAT_OUT == ($past(STAT_IN) ^ $past(inv_out_r))))
		else $error("output inversion wrong"); // RL15
	a_dead_zone_zero: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		in_dz |=> (SPD_CMD == 32'sh0)) else $error("dead zone not zero"); // RL4
	a_speed_dir: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(!in_dz && spd_rev_r) |=> (SPD_CMD == -$past(spd_mul)))
		else $error("speed reverse wrong"); // RL2 RL1
	a_torque_dir: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		!trq_rev_r |=> (TRQ_CMD == $past(trq_mul))) else $error("torque sense wrong"); // RL7 RL6
	a_speed_cap: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		trq_mode_r |=> (SPD_LIMIT == $past(trq_cap_r))) else $error("speed cap wrong"); // RL9
	a_debounce_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(deb_r[0] != $past(deb_r[0])) |-> $past(deb_tick)) else $error("debounce early"); // RL16
	a_filter_full: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(spd_flt_r == `SCI_FLT_FULL) |=> (spd_f_r == $past(spd_corr)))
		else $error("speed filter wrong"); // RL5 RL3
	a_tfilter_full: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		(trq_flt_r == `SCI_FLT_FULL) |=> (trq_f_r == $past(trq_corr)))
		else $error("torque filter wrong"); // RL10 RL8

	// Register bus steps, written once and reused below
	sequence s_wr_spd_gain;
		REG_WR && (REG_ADDR == `SCI_IDX_SPD_GAIN);
	endsequence

	sequence s_wr_trq_gain;
		REG_WR && (REG_ADDR == `SCI_IDX_TRQ_GAIN);
	endsequence

	sequence s_wr_frc_lo;
		REG_WR && (REG_ADDR == `SCI_IDX_FRC_LO);
	endsequence

	sequence s_wr_inv_out;
		REG_WR && (REG_ADDR == `SCI_IDX_INV_OUT);
	endsequence

	sequence s_rd_status;
		REG_RD && (REG_ADDR == `SCI_IDX_STATUS);
	endsequence

	sequence s_rd_unmapped;
		REG_RD && (REG_ADDR > `SCI_IDX_TRQ_MODE);
	endsequence

	// Debounce take step: pin differs, tick due, count reached
	sequence s_deb_take_lo;
		deb_tick && (raw_in[0] != deb_r[0]) && ((deb_cnt_r[0] + 16'h0001) >= deb_time_r);
	endsequence

	sequence s_deb_take_hi;
		deb_tick && (raw_in[4] != deb_r[4]) && ((deb_cnt_r[4] + 16'h0001) >= deb_time_r);
	endsequence

	// Read data stands one cycle, zero otherwise
	a_rdata_idle: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		!REG_RD |=> (REG_RDATA == 16'h0000))
		else $error("read data not idle");
	a_rdata_status: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL17
		s_rd_status |=> (REG_RDATA == {8'h00, $past(TERM_OUT.hi), $past(TERM_OUT.lo)}))
		else $error("status read wrong");
	a_rdata_unmapped: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
		s_rd_unmapped |=> (REG_RDATA == 16'h0000))
		else $error("unmapped read not zero");

	// Writes land on the following edge
	a_write_gain: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL1
		s_wr_spd_gain |=> (spd_gain_r == $past(REG_WDATA)))
		else $error("speed gain write lost");
	a_write_tgain: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL6
		s_wr_trq_gain |=> (trq_gain_r == $past(REG_WDATA)))
		else $error("torque gain write lost");
	a_write_force: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL11
		s_wr_frc_lo |=> (frc_lo_r == $past(REG_WDATA[3:0])))
		else $error("force word write lost");
	a_write_outinv: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL15
		s_wr_inv_out |=> (inv_out_r == $past(REG_WDATA[3:0])))
		else $error("output invert write lost");

	// Command sense in the other direction setting
	a_speed_fwd: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL2 RL1
		(!in_dz && !spd_rev_r) |=> (SPD_CMD == $past(spd_mul)))
		else $error("speed forward wrong");
	a_torque_rev: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL7 RL6
		trq_rev_r |=> (TRQ_CMD == -$past(trq_mul)))
		else $error("torque reverse wrong");

	// No cap outside torque mode
	a_cap_off: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL9
		!trq_mode_r |=> (SPD_LIMIT == 16'sh7FFF))
		else $error("speed cap active outside torque mode");

	// Zero offset leaves the sample untouched
	a_offset_spd: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL3
		(spd_ofs_r == 16'h0000) |-> (spd_corr == ANA_IN.spd))
		else $error("speed offset wrong");
	a_offset_trq: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL8
		(trq_ofs_r == 16'h0000) |-> (trq_corr == ANA_IN.trq))
		else $error("torque offset wrong");

	// Debounce takes the pin once the count is reached
	a_deb_take_lo: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL16
		s_deb_take_lo |=> (deb_r[0] == $past(raw_in[0])))
		else $error("low debounce not taken");
	a_deb_take_hi: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL16
		s_deb_take_hi |=> (deb_r[4] == $past(raw_in[4])))
		else $error("high debounce not taken");
	a_deb_restart: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL16
		(raw_in[0] == deb_r[0]) |=> (deb_cnt_r[0] == 16'h0000))
		else $error("debounce count not cleared");
	a_debounce_hi: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) // RL16
		(deb_r[4] != $past(deb_r[4])) |-> $past(deb_tick))
		else $error("high debounce early");
endmodule
`default_nettype wire

// ### test/sci_ctrl_model.sv
/*
 Motion controller model: analog speed and torque samples and input terminal pins.
 Assumes the bench changes requests right after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module sci_ctrl_model (
	input  wire logic signed [15:0] spd_req,
	input  wire logic signed [15:0] trq_req,
	input  wire logic [3:0]         lo_req,
	input  wire logic [3:0]         hi_req,
	output var sci_pkg::sci_ana_s   ana_out,
	output var sci_pkg::sci_term_s  pin_out
);
	// Controller holds every level until told otherwise
	assign ana_out = '{spd: spd_req, trq: trq_req};
	assign pin_out = '{lo: lo_req, hi: hi_req};
endmodule
`default_nettype wire

// ### test/tb.sv
/*
 Self-checking bench for the servo command conditioning core.
 Assumes the package is compiled first and a short debounce tick.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct {
		int x, ofs, gain, rev, dz, tx, tofs, tgain, trev, espd, etrq;
	} sci_row_s;
	sci_row_s rows [5] = '{
		'{100, 0, 300, 0, 0, 50, 0, 100, 0, 30000, 5000},
		'{100, -20, 10, 1, 0, -50, 10, 600, 1, -800, 24000},
		'{30, 0, 5, 0, 30, 0, 500, 10, 0, 0, 5000},
		'{31, 0, 3000, 0, -30, -7, -500, 600, 0, 93000, -304200},
		'{-30, 0, 7, 1, 30, 500, 0, 10, 1, 0, -5000}};
	logic [15:0] rst_val [16] = '{16'h012C, 16'h0000, 16'h0000, 16'h0000, 16'h012C,
		16'h0064, 16'h0000, 16'h0000, 16'h09C4, 16'h012C, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0010};
	logic                clk_sys = 1'b0;
	logic                sys_rst = 1'b1;
	logic [4:0]          reg_addr = 5'h00;
	logic [15:0]         reg_wdata = 16'h0000;
	logic                reg_wr = 1'b0;
	logic                reg_rd = 1'b0;
	logic [15:0]         reg_rdata;
	logic [3:0]          stat_in = 4'h0;
	logic [3:0]          lo_req = 4'h0;
	logic [3:0]          hi_req = 4'h0;
	logic signed [15:0]  spd_req = 16'h0000;
	logic signed [15:0]  trq_req = 16'h0000;
	sci_pkg::sci_ana_s   ana;
	sci_pkg::sci_term_s  term_in;
	sci_pkg::sci_term_s  term_out;
	logic [3:0]          stat_out;
	logic signed [31:0]  spd_cmd;
	logic signed [31:0]  trq_cmd;
	logic signed [15:0]  spd_limit;
	int                  errors = 0;
	int                  checks_done = 0;

	// Clock at 50 ns
	always #25 clk_sys = ~clk_sys;

	sci_core #(.DEB_TICK(1)) uut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.ANA_IN(ana), .TERM_IN(term_in), .STAT_IN(stat_in), .TERM_OUT(term_out),
		.STAT_OUT(stat_out), .SPD_CMD(spd_cmd), .TRQ_CMD(trq_cmd), .SPD_LIMIT(spd_limit));
	sci_ctrl_model ctrl (.spd_req(spd_req), .trq_req(trq_req), .lo_req(lo_req),
		.hi_req(hi_req), .ana_out(ana), .pin_out(term_in));

	// Compare and count
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	// One-cycle register write
	task automatic wr(input logic [4:0] a, input int d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d[15:0];
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// Read, data checked in the following cycle
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk("reg_rdata", {16'h0000, reg_rdata}, {16'h0000, e});
	endtask

	// Let pipelines settle
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask

	task automatic finish_test;
		$display("checks_done %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Watchdog
	initial begin
		#(50 * 20000);
		errors++;
		finish_test;
	end

	// Main sequence
	initial begin
		repeat (10) @(posedge clk_sys);
		chk("spd_cmd_rst", spd_cmd, 0);
		sys_rst <= 1'b0;
		for (int i = 0; i < 16; i++) rd(i[4:0], rst_val[i]);
		settle(1);
		chk("spd_limit_off", {16'h0000, spd_limit}, 32'h7FFF);
		rd(5'h1F, 16'h0000);
		wr(5'h1F, 16'hFFFF);
		rd(5'h1F, 16'h0000);
		wr(5'h0A, 16'h00F5);
		rd(5'h0A, 16'h0005);
		wr(5'h04, 1000);
		wr(5'h09, 1000);
		// Table of analog cases, filters fully open
		foreach (rows[i]) begin
			wr(5'h00, rows[i].gain);
			wr(5'h01, rows[i].rev);
			wr(5'h02, rows[i].ofs);
			wr(5'h03, rows[i].dz);
			wr(5'h05, rows[i].tgain);
			wr(5'h06, rows[i].trev);
			wr(5'h07, rows[i].tofs);
			@(posedge clk_sys);
			spd_req <= rows[i].x[15:0];
			trq_req <= rows[i].tx[15:0];
			settle(4);
			chk("spd_cmd", spd_cmd, rows[i].espd);
			chk("trq_cmd", trq_cmd, rows[i].etrq);
		end
		// Filter step at half setting
		wr(5'h00, 1);
		wr(5'h01, 0);
		wr(5'h03, 0);
		@(posedge clk_sys);
		spd_req <= 16'h0000;
		trq_req <= 16'h0000;
		settle(3);
		wr(5'h04, 500);
		wr(5'h09, 500);
		@(posedge clk_sys);
		spd_req <= 16'h03E8;
		trq_req <= 16'h03E8;
		settle(2);
		chk("spd_step1", spd_cmd, 500);
		chk("trq_step1", trq_cmd, -5000);
		@(negedge clk_sys);
		chk("spd_step2", spd_cmd, 750);
		chk("trq_step2", trq_cmd, -7500);
		// Speed cap in torque mode
		wr(5'h11, 1);
		settle(3);
		chk("spd_limit", {16'h0000, spd_limit}, 32'h09C4);
		wr(5'h08, 16'h0FA0);
		settle(3);
		chk("spd_limit", {16'h0000, spd_limit}, 32'h0FA0);
		// Terminal inversion and force
		wr(5'h0F, 1);
		wr(5'h0C, 16'h0005);
		wr(5'h0A, 16'h0008);
		wr(5'h0D, 16'h0006);
		wr(5'h0B, 16'h0001);
		wr(5'h0E, 16'h0006);
		@(posedge clk_sys);
		lo_req <= 4'h3;
		hi_req <= 4'hA;
		stat_in <= 4'hA;
		settle(10);
		chk("term_lo", term_out.lo, 4'hE);
		chk("term_hi", term_out.hi, 4'hD);
		chk("stat_out", stat_out, 4'hC);
		rd(5'h10, 16'h00DE);
		rd(5'h11, 16'h0001);
		// Debounce: short glitch rejected, steady change taken
		wr(5'h0F, 4);
		@(posedge clk_sys);
		lo_req <= 4'h2;
		repeat (2) @(posedge clk_sys);
		lo_req <= 4'h3;
		settle(10);
		chk("term_glitch", term_out.lo, 4'hE);
		@(posedge clk_sys);
		lo_req <= 4'h2;
		settle(2);
		chk("term_early", term_out.lo, 4'hE);
		settle(10);
		chk("term_late", term_out.lo, 4'hF);
		wr(5'h0B, 16'h000F);
		settle(2);
		chk("term_force", term_out.hi, 4'hF);
		// Mid-run reset returns outputs and registers to defaults
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		settle(2);
		chk("spd_cmd_rst2", spd_cmd, 0);
		chk("term_rst2", {24'h000000, term_out}, 0);
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(5'h0B, 16'h0000);
		rd(5'h11, 16'h0000);
		settle(1);
		chk("spd_limit_rst2", {16'h0000, spd_limit}, 32'h7FFF);
		finish_test;
	end
endmodule
`default_nettype wire
